// ---- sac_adc_ctrl.sv ----
// Top of the converter control block: registers, triggers and pin logic.
//
// Behaviour
// [RULE1] Convert held input to 8-bit by search.
// [RULE2] Three-bit channel code picks four inputs.
// [RULE3] Software selects supply or external reference.
// [RULE4] Clock select sets bit period source.
// [RULE5] Writing go starts; go reads busy.
// [RULE6] Done loads result, clears go, flags.
// [RULE7] Conversion lasts nine and half periods.
// [RULE8] Software keeps bit period above minimum.
// [RULE9] Hold capacitor disconnects at conversion start.
// [RULE10] Wait acquisition time before any start.
// [RULE11] Wait two periods before next acquisition.
// [RULE12] Enable module before setting go.
// [RULE13] Reset restores registers, aborts, powers off.
// [RULE14] Result register keeps value across reset.
// [RULE15] Trigger in mode 1011 sets go.
// [RULE16] Trigger ignored when off; timer reset.
// [RULE17] Sleep operation only on RC clock.
// [RULE18] Above 1 MHz, RC only for sleep.
// [RULE19] Analog pins read zero on port.
// [RULE20] Conversion ignores pin direction bits.
// [RULE21] Interrupt setup and flag clearing sequence.
// [RULE22] Off: no current, go writes ignored.
// [RULE23] Reserved channel codes select no input.
`timescale 1ns/1ps
`default_nettype none
module sac_adc_ctrl
    import sac_pkg::*;
(
    // Clock, reset, enable.
    input wire logic I_CLOCK,
    input wire logic I_RSTN,
    input wire logic I_CE,
    // Register port.
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    // Completion flag towards the interrupt flag register.
    output logic O_DONE_FLAG,
    input wire logic I_DONE_FLAG_CLR,
    // System context.
    input wire logic I_SLEEP,
    input wire logic I_RC_TICK,
    // Capture/compare special event.
    input wire logic [3:0] I_CCP_MODE,
    input wire logic I_SPECIAL_TRIG,
    output logic O_TMR1_RESET,
    // Analog front end.
    input wire logic I_CMP,
    output logic [7:0] O_DAC_TRIAL,
    output logic [1:0] O_CHAN,
    output logic O_CHAN_VALID,
    output logic O_REF_EXT,
    output logic O_HOLD_OPEN,
    output logic O_POWER_ON,
    // Port A data path.
    input wire logic [3:0] I_PORT_PINS,
    output logic [3:0] O_PORT_READ
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    sac_ctrl_t ctrl_ff, nxt_ctrl;
    logic [2:0] cfg_ff, nxt_cfg;
    logic [7:0] result_ff, nxt_result;
    logic [7:0] rdata_ff, nxt_rdata;
    logic done_flag_ff, nxt_done_flag;
    logic tmr_rst_ff, nxt_tmr_rst;
    logic [3:0] port_rd_ff, nxt_port_rd;
    sac_ctrl_t wctrl;
    sac_pin_cfg_t pin_cfg;
    logic wr_ctrl, trig_hit, sw_start, start, abort;
    logic half_tick, busy, done;
    logic [7:0] code;

    assign wctrl = sac_ctrl_t'(I_WDATA);
    assign wr_ctrl = I_WR && (I_ADDR == ADDR_CTRL);
    assign pin_cfg = sac_decode_cfg(cfg_ff);

    // ---------------------------------------------------------------
    // Start, abort and trigger decode
    // ---------------------------------------------------------------
    // The module must already be on; a write that turns it on and sets go
    // together does not start, so acquisition always follows power up.
    // [RULE22] off blocks software start
    assign sw_start = wr_ctrl && wctrl.go && ctrl_ff.on && wctrl.on;
    // [RULE15] trigger starts when enabled
    assign trig_hit = I_SPECIAL_TRIG && (I_CCP_MODE == CCP_MODE_TRIG);
    assign start = !busy && (sw_start || (trig_hit && ctrl_ff.on));
    // Clearing go or power by software abandons the conversion.
    assign abort = busy && wr_ctrl && (!wctrl.go || !wctrl.on);

    // ---------------------------------------------------------------
    // Sub-blocks
    // ---------------------------------------------------------------
    // The tick counter idles at zero, so each conversion on a divided clock opens on a full half period.
    sac_tad_gen u_tad (
        .i_clk(I_CLOCK),
        .i_rstn(I_RSTN),
        .i_ce(I_CE),
        .i_run(busy),
        .i_clk_sel(ctrl_ff.clk_sel),
        .i_rc_tick(I_RC_TICK),
        .i_sleep(I_SLEEP),
        .o_half_tick(half_tick)
    );

    // The engine owns the trial word; the analog side compares against it.
    sac_sar_engine u_sar (
        .i_clk(I_CLOCK),
        .i_rstn(I_RSTN),
        .i_ce(I_CE),
        .i_start(start),
        .i_abort(abort),
        .i_half_tick(half_tick),
        .i_cmp(I_CMP),
        .o_busy(busy),
        .o_done(done),
        .o_code(code)
    );

    // ---------------------------------------------------------------
    // Register next values
    // ---------------------------------------------------------------
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_cfg = cfg_ff;
        nxt_result = result_ff;
        if (wr_ctrl) begin
            nxt_ctrl.clk_sel = wctrl.clk_sel;
            nxt_ctrl.chan = wctrl.chan;
            nxt_ctrl.on = wctrl.on;
            // [RULE5] go follows a software start
            nxt_ctrl.go = sw_start || (busy && !abort);
        end
        if (I_WR && I_ADDR == ADDR_CFG) begin
            nxt_cfg = I_WDATA[2:0];
        end
        if (I_WR && I_ADDR == ADDR_RESULT) begin
            nxt_result = I_WDATA;
        end
        // [RULE15] hardware trigger sets go
        if (start) begin
            nxt_ctrl.go = 1'b1;
        end
        // [RULE6] completion loads and clears go
        if (done) begin
            nxt_ctrl.go = 1'b0;
            nxt_result = code;
        end
        nxt_ctrl.rsv = 1'b0;
    end

    // [RULE13] reset restores control and aborts
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ctrl_ff <= sac_ctrl_t'(CTRL_RESET);
            cfg_ff <= CFG_RESET;
        end else if (I_CE) begin
            ctrl_ff <= nxt_ctrl;
            cfg_ff <= nxt_cfg;
        end
    end

    // [RULE14] result has no reset term
    always_ff @(posedge I_CLOCK) begin
        if (I_CE) begin
            result_ff <= nxt_result;
        end
    end

    // ---------------------------------------------------------------
    // Read data, flag, timer reset and port view
    // ---------------------------------------------------------------
    // Unmapped addresses read zero, so a stray read never shows stale data.
    always_comb begin
        case (I_ADDR)
            ADDR_RESULT: nxt_rdata = result_ff;
            ADDR_CTRL: nxt_rdata = ctrl_ff;
            ADDR_CFG: nxt_rdata = {5'h00, cfg_ff};
            default: nxt_rdata = RDATA_NONE;
        endcase
        if (!I_RD) begin
            nxt_rdata = RDATA_NONE;
        end
        // Set wins over clear, so a completion in the clear cycle survives.
        nxt_done_flag = done || (done_flag_ff && !I_DONE_FLAG_CLR);
        // [RULE16] timer reset regardless of power
        nxt_tmr_rst = trig_hit;
        // [RULE19] analog pins read as zero
        // [RULE20] direction bits never gate conversion
        nxt_port_rd = I_PORT_PINS & ~pin_cfg.analog;
    end

    // Read data is zero outside the cycle after a read strobe.
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rdata_ff <= RDATA_NONE;
            done_flag_ff <= 1'b0;
            tmr_rst_ff <= 1'b0;
            port_rd_ff <= 4'h0;
        end else if (I_CE) begin
            rdata_ff <= nxt_rdata;
            done_flag_ff <= nxt_done_flag;
            tmr_rst_ff <= nxt_tmr_rst;
            port_rd_ff <= nxt_port_rd;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign O_RDATA = rdata_ff;
    assign O_DONE_FLAG = done_flag_ff;
    assign O_TMR1_RESET = tmr_rst_ff;
    assign O_PORT_READ = port_rd_ff;
    assign O_DAC_TRIAL = code;
    // [RULE2] low channel bits pick input
    assign O_CHAN = ctrl_ff.chan[1:0];
    // [RULE23] reserved codes select nothing
    assign O_CHAN_VALID = !ctrl_ff.chan[2];
    // [RULE3] reference from port configuration
    assign O_REF_EXT = pin_cfg.ext_ref;
    // [RULE9] hold capacitor open while converting
    assign O_HOLD_OPEN = busy;
    // [RULE22] analog bias only when on
    assign O_POWER_ON = ctrl_ff.on;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    // Properties sample registered state and decoded inputs at the edge, so each sees settled values.
    sequence s_sw_go;
        I_CE && wr_ctrl && wctrl.go && wctrl.on && ctrl_ff.on && !busy;
    endsequence

    property p_go_start;
        @(posedge I_CLOCK) disable iff (!I_RSTN)
        s_sw_go |=> ctrl_ff.go && busy;
    endproperty
    a_go_start: assert property (p_go_start) else $error("go write did not start"); // [RULE5]

    property p_done;
        @(posedge I_CLOCK) disable iff (!I_RSTN)
        (I_CE && done) |=> !ctrl_ff.go && O_DONE_FLAG && (result_ff == $past(code));
    endproperty
    a_done: assert property (p_done) else $error("completion effects missing"); // [RULE6]

    property p_off_ignore;
        @(posedge I_CLOCK) disable iff (!I_RSTN)
        (I_CE && !ctrl_ff.on && !busy && wr_ctrl && !I_SPECIAL_TRIG) |=> !ctrl_ff.go;
    endproperty
    a_off_ignore: assert property (p_off_ignore) else $error("start while off"); // [RULE22]

    property p_trig;
        @(posedge I_CLOCK) disable iff (!I_RSTN)
        (I_CE && trig_hit && ctrl_ff.on && !busy && !wr_ctrl) |=> ctrl_ff.go ##0 busy;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger did not start"); // [RULE15]

    property p_tmr;
        @(posedge I_CLOCK) disable iff (!I_RSTN)
        (I_CE && trig_hit) |=> O_TMR1_RESET;
    endproperty
    a_tmr: assert property (p_tmr) else $error("timer reset missing"); // [RULE16]

    property p_hold;
        @(posedge I_CLOCK) disable iff (!I_RSTN)
        ctrl_ff.go |-> O_HOLD_OPEN;
    endproperty
    a_hold: assert property (p_hold) else $error("hold not open"); // [RULE9]

    // The port view lags the configuration by one flop, hence the past mask.
    property p_port;
        @(posedge I_CLOCK) disable iff (!I_RSTN)
        I_CE |=> (O_PORT_READ & $past(pin_cfg.analog)) == 4'h0;
    endproperty
    a_port: assert property (p_port) else $error("analog pin reads one"); // [RULE19]

    property p_flag_keep;
        @(posedge I_CLOCK) disable iff (!I_RSTN)
        (I_CE && done && I_DONE_FLAG_CLR) |=> O_DONE_FLAG;
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("flag lost on clear"); // [RULE6]

    // Go and busy rise and fall on the same edges, so go reads one throughout.
    property p_go_busy;
        @(posedge I_CLOCK) disable iff (!I_RSTN)
        busy |-> ctrl_ff.go;
    endproperty
    a_go_busy: assert property (p_go_busy) else $error("busy without go"); // [RULE5]

    property p_abort;
        @(posedge I_CLOCK) disable iff (!I_RSTN)
        (I_CE && abort) |=> !busy && !ctrl_ff.go;
    endproperty
    a_abort: assert property (p_abort) else $error("abort left conversion running"); // [RULE5]
endmodule
`default_nettype wire

// ---- sac_adc_ctrl_bench.sv ----
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module sac_adc_ctrl_bench
    import sac_pkg::*;
;

    // Channel levels ch3..ch0 and the chosen port configuration decode.
    localparam logic [31:0] LEVELS = 32'h00FF3CA5;
    localparam logic [31:0] MASKS = 32'h0011337F;
    localparam logic [7:0] EXTS = 8'h2A;
    logic I_CLOCK, I_RSTN, I_WR, I_RD, I_DONE_FLAG_CLR, I_SLEEP, I_RC_TICK;
    logic I_SPECIAL_TRIG, I_CMP, O_DONE_FLAG, O_TMR1_RESET, O_CHAN_VALID;
    logic O_REF_EXT, O_HOLD_OPEN, O_POWER_ON, rc_en;
    logic [7:0] I_ADDR, I_WDATA, O_RDATA, O_DAC_TRIAL;
    logic [3:0] I_CCP_MODE, I_PORT_PINS, O_PORT_READ;
    logic [1:0] O_CHAN;
    logic [2:0] rc_cnt = 3'h0;
    int mismatches, comparisons, n;

    sac_adc_ctrl i_dut (.I_CLOCK(I_CLOCK), .I_RSTN(I_RSTN), .I_CE(1'b1), .I_ADDR(I_ADDR),
        .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
        .O_DONE_FLAG(O_DONE_FLAG), .I_DONE_FLAG_CLR(I_DONE_FLAG_CLR), .I_SLEEP(I_SLEEP),
        .I_RC_TICK(I_RC_TICK), .I_CCP_MODE(I_CCP_MODE), .I_SPECIAL_TRIG(I_SPECIAL_TRIG),
        .O_TMR1_RESET(O_TMR1_RESET), .I_CMP(I_CMP), .O_DAC_TRIAL(O_DAC_TRIAL),
        .O_CHAN(O_CHAN), .O_CHAN_VALID(O_CHAN_VALID), .O_REF_EXT(O_REF_EXT),
        .O_HOLD_OPEN(O_HOLD_OPEN), .O_POWER_ON(O_POWER_ON), .I_PORT_PINS(I_PORT_PINS),
        .O_PORT_READ(O_PORT_READ));
    sac_analog_model i_model (.i_clk(I_CLOCK), .i_levels(LEVELS), .i_trial(O_DAC_TRIAL),
        .i_chan(O_CHAN), .i_chan_valid(O_CHAN_VALID), .i_hold_open(O_HOLD_OPEN),
        .o_cmp(I_CMP));

    // ---------------------------------------------------------------
    // Clock and internal RC oscillator
    // ---------------------------------------------------------------
    initial begin
        I_CLOCK = 1'b0;
        forever #4 I_CLOCK = ~I_CLOCK;
    end
    // One RC pulse every five clocks, only while enabled.
    always @(posedge I_CLOCK) begin
        rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
        I_RC_TICK <= rc_en && (rc_cnt == 3'h4);
    end

    // ---------------------------------------------------------------
    // Access tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge I_CLOCK);
        I_ADDR <= a;
        I_WDATA <= d;
        I_WR <= 1'b1;
        @(posedge I_CLOCK);
        I_WR <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge I_CLOCK);
        I_ADDR <= a;
        I_RD <= 1'b1;
        @(posedge I_CLOCK);
        I_RD <= 1'b0;
        #1 chk(O_RDATA, exp);
    endtask
    // Counts clocks while the capacitor is open, bounded so a hang shows.
    task automatic wait_idle();
        n = 0;
        while (O_HOLD_OPEN === 1'b1 && n < 2000) begin
            @(posedge I_CLOCK);
            #1 n++;
        end
    endtask
    task automatic clr_flag();
        @(posedge I_CLOCK);
        I_DONE_FLAG_CLR <= 1'b1;
        @(posedge I_CLOCK);
        I_DONE_FLAG_CLR <= 1'b0;
        #1 chk(O_DONE_FLAG, 1'b0);
    endtask
    task automatic conv(input logic [1:0] sel, input logic [2:0] ch, input int half);
        wr(ADDR_CTRL, {sel, ch, 3'b001});
        repeat (4) @(posedge I_CLOCK);
        wr(ADDR_CTRL, {sel, ch, 3'b101});
        chk(O_HOLD_OPEN, 1'b1);
        chk(O_CHAN, ch[1:0]);
        rchk(ADDR_CTRL, {sel, ch, 3'b101});
        wait_idle();
        if (half > 0) begin
            chk(16'(n), 16'(half * 19 - 2));
        end
        chk(O_DONE_FLAG, 1'b1);
        chk(O_DAC_TRIAL, LEVELS[ch[1:0]*8 +: 8]);
        rchk(ADDR_CTRL, {sel, ch, 3'b001});
        rchk(ADDR_RESULT, LEVELS[ch[1:0]*8 +: 8]);
        clr_flag();
        repeat (40) @(posedge I_CLOCK);
    endtask
    task automatic trig(input logic [3:0] mode, input logic on, input logic started);
        wr(ADDR_CTRL, {7'h00, on});
        @(posedge I_CLOCK);
        I_CCP_MODE <= mode;
        I_SPECIAL_TRIG <= 1'b1;
        @(posedge I_CLOCK);
        I_SPECIAL_TRIG <= 1'b0;
        #1 chk(O_TMR1_RESET, mode == CCP_MODE_TRIG);
        chk(O_HOLD_OPEN, started);
        wait_idle();
        chk(O_DONE_FLAG, started);
        clr_flag();
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Watchdog: the tests need about 3000 clocks.
    // ---------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge I_CLOCK);
        mismatches++;
        results();
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        {I_RSTN, I_WR, I_RD, I_DONE_FLAG_CLR, I_SLEEP, I_SPECIAL_TRIG, rc_en} = '0;
        {I_ADDR, I_WDATA, I_CCP_MODE} = '0;
        I_PORT_PINS = 4'hF;
        repeat (6) @(posedge I_CLOCK);
        I_RSTN <= 1'b1;
        rchk(ADDR_CTRL, CTRL_RESET);
        rchk(ADDR_CFG, 8'h00);
        rchk(8'h20, RDATA_NONE);
        wr(ADDR_RESULT, 8'h5A);
        rchk(ADDR_RESULT, 8'h5A);
        wr(ADDR_CTRL, 8'h04);
        rchk(ADDR_CTRL, 8'h00);
        chk(O_POWER_ON, 1'b0);
        wr(ADDR_CTRL, 8'h05);
        rchk(ADDR_CTRL, 8'h01);
        wr(ADDR_CTRL, 8'h21);
        chk(O_CHAN_VALID, 1'b0);
        $display("test registers done");
        for (int s = 0; s < 3; s++) begin
            for (int c = 0; c < 4; c++) begin
                conv(2'(s), 3'(c), (s == 0) ? 1 : (s == 1) ? 4 : 16);
            end
        end
        $display("test conversions done");
        // A divided clock stalls in sleep; the RC clock keeps running.
        I_SLEEP <= 1'b1;
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_CTRL, 8'h05);
        repeat (50) @(posedge I_CLOCK);
        I_SLEEP <= 1'b0;
        #1 chk(O_HOLD_OPEN, 1'b1);
        wait_idle();
        rchk(ADDR_RESULT, LEVELS[7:0]);
        clr_flag();
        @(posedge I_CLOCK);
        rc_en <= 1'b1;
        I_SLEEP <= 1'b1;
        conv(CLK_RC, 3'h2, 0);
        I_SLEEP <= 1'b0;
        $display("test sleep done");
        trig(CCP_MODE_TRIG, 1'b1, 1'b1);
        trig(CCP_MODE_TRIG, 1'b0, 1'b0);
        trig(4'hA, 1'b1, 1'b0);
        $display("test trigger done");
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_CFG, 8'(c));
            repeat (2) @(posedge I_CLOCK);
            #1 chk(O_PORT_READ, ~MASKS[c*4 +: 4] & I_PORT_PINS);
            chk(O_REF_EXT, EXTS[c]);
            rchk(ADDR_CFG, 8'(c));
        end
        $display("test port config done");
        wr(ADDR_CTRL, 8'h89);
        wr(ADDR_CTRL, 8'h8D);
        repeat (20) @(posedge I_CLOCK);
        wr(ADDR_CTRL, 8'h89);
        @(posedge I_CLOCK);
        #1 chk(O_HOLD_OPEN, 1'b0);
        repeat (320) @(posedge I_CLOCK);
        #1 chk(O_DONE_FLAG, 1'b0);
        wr(ADDR_CTRL, 8'h95);
        repeat (20) @(posedge I_CLOCK);
        I_RSTN <= 1'b0;
        repeat (6) @(posedge I_CLOCK);
        I_RSTN <= 1'b1;
        #1 chk({O_HOLD_OPEN, O_POWER_ON, O_DONE_FLAG}, 3'h0);
        rchk(ADDR_CTRL, CTRL_RESET);
        // The last finished conversion was channel 0, started by the trigger.
        rchk(ADDR_RESULT, LEVELS[7:0]);
        $display("test abort and reset done");
        results();
    end
endmodule
`default_nettype wire

// ---- sac_analog_model.sv ----
// Behavioural model of the analog inputs and the sample-and-hold comparator.
`timescale 1ns/1ps
`default_nettype none
module sac_analog_model (
    // Clock and analog levels.
    input wire logic i_clk,
    input wire logic [31:0] i_levels,
    // Front-end controls from the block.
    input wire logic [7:0] i_trial,
    input wire logic [1:0] i_chan,
    input wire logic i_chan_valid,
    input wire logic i_hold_open,
    // Comparator result.
    output logic o_cmp
);
    logic [7:0] held_ff;

    // ---------------------------------------------------------------
    // Sample and hold
    // ---------------------------------------------------------------
    // The capacitor tracks the selected pin while closed and freezes when opened.
    // A reserved channel gives a level that changes every cycle.
    // freeze while open
    always @(posedge i_clk) begin
        if (!i_hold_open) begin
            held_ff <= i_chan_valid ? i_levels[i_chan*8 +: 8] : ~held_ff;
        end
    end

    // The comparator answers at once against the trial word.
    assign o_cmp = (held_ff >= i_trial);
endmodule
`default_nettype wire

// ---- sac_pkg.sv ----
// Constants, field layouts and types shared by the converter control block.
`default_nettype none
package sac_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_RESULT = 8'h1E;
    localparam logic [7:0] ADDR_CTRL = 8'h1F;
    localparam logic [7:0] ADDR_CFG = 8'h9F;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [2:0] CFG_RESET = 3'h0;
    localparam logic [7:0] RDATA_NONE = 8'h00;

    // ---------------------------------------------------------------
    // Modes and codes
    // ---------------------------------------------------------------
    localparam logic [1:0] CLK_DIV2 = 2'h0;
    localparam logic [1:0] CLK_DIV8 = 2'h1;
    localparam logic [1:0] CLK_DIV32 = 2'h2;
    localparam logic [1:0] CLK_RC = 2'h3;
    localparam logic [3:0] CCP_MODE_TRIG = 4'hB;

    // Half bit periods in system clocks for the divide-by-2 and divide-by-8 sources; divide-by-32 gives its last count.
    localparam logic [3:0] HALF_DIV2 = 4'h1;
    localparam logic [3:0] HALF_DIV8 = 4'h4;
    localparam logic [3:0] HALF_DIV32 = 4'hF;
    localparam logic [3:0] HALF_DIV32_LAST = 4'hF;
    // A conversion is 9.5 bit periods, that is 19 half periods.
    localparam logic [4:0] HALF_LAST = 5'h12;
    localparam logic [4:0] HALF_DECIDE_END = 5'h10;
    localparam logic [7:0] SAR_START = 8'h80;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0] clk_sel;
        logic [2:0] chan;
        logic go;
        logic rsv;
        logic on;
    } sac_ctrl_t;

    typedef struct packed {
        logic [3:0] analog;
        logic ext_ref;
    } sac_pin_cfg_t;

    // Port configuration code to analog pin mask and reference source.
    function automatic sac_pin_cfg_t sac_decode_cfg(input logic [2:0] code);
        sac_pin_cfg_t r;
        case (code)
            3'h0: r = '{analog: 4'hF, ext_ref: 1'b0};
            3'h1: r = '{analog: 4'h7, ext_ref: 1'b1};
            3'h2: r = '{analog: 4'h3, ext_ref: 1'b0};
            3'h3: r = '{analog: 4'h3, ext_ref: 1'b1};
            3'h4: r = '{analog: 4'h1, ext_ref: 1'b0};
            3'h5: r = '{analog: 4'h1, ext_ref: 1'b1};
            default: r = '{analog: 4'h0, ext_ref: 1'b0};
        endcase
        return r;
    endfunction

endpackage
`default_nettype wire

// ---- sac_sar_engine.sv ----
// Successive-approximation sequencer over nineteen half bit periods.
`timescale 1ns/1ps
`default_nettype none
module sac_sar_engine
    import sac_pkg::*;
(
    // Clock, reset, enable.
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // Control.
    input wire logic i_start,
    input wire logic i_abort,
    input wire logic i_half_tick,
    input wire logic i_cmp,
    // Status and data.
    output logic o_busy,
    output logic o_done,
    output logic [7:0] o_code
);
    typedef enum logic {SAC_IDLE, SAC_CONV} sac_state_t;
    sac_state_t st_ff, nxt_st;
    logic [4:0] cnt_ff, nxt_cnt;
    logic [7:0] sar_ff, nxt_sar;
    logic [2:0] idx;

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    // Odd half counts below sixteen decide bits seven down to zero.
    assign idx = 3'h7 - cnt_ff[3:1];

    // [RULE1] binary search on held value
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_sar = sar_ff;
        o_done = 1'b0;
        case (st_ff)
            SAC_IDLE: begin
                if (i_start) begin
                    nxt_st = SAC_CONV;
                    nxt_cnt = 5'h00;
                    nxt_sar = SAR_START;
                end
            end
            SAC_CONV: begin
                if (i_abort) begin
                    nxt_st = SAC_IDLE;
                end else if (i_half_tick) begin
                    nxt_cnt = cnt_ff + 5'h01;
                    if (cnt_ff[0] && cnt_ff < HALF_DECIDE_END) begin
                        nxt_sar[idx] = i_cmp;
                        if (idx != 3'h0) begin
                            nxt_sar[idx - 3'h1] = 1'b1;
                        end
                    end
                    // [RULE7] done on nineteenth half period
                    if (cnt_ff == HALF_LAST) begin
                        nxt_st = SAC_IDLE;
                        o_done = 1'b1;
                    end
                end
            end
            default: nxt_st = SAC_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_ff <= SAC_IDLE;
            cnt_ff <= 5'h00;
            sar_ff <= 8'h00;
        end else if (i_ce) begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            sar_ff <= nxt_sar;
        end
    end

    assign o_busy = (st_ff == SAC_CONV);
    assign o_code = sar_ff;

    property p_len;
        @(posedge i_clk) disable iff (!i_rstn)
        o_done |-> (cnt_ff == HALF_LAST) && i_half_tick && o_busy;
    endproperty
    a_len: assert property (p_len) else $error("conversion length wrong"); // [RULE7]
endmodule
`default_nettype wire

// ---- sac_tad_gen.sv ----
// Half bit-period tick generator for the conversion clock.
`timescale 1ns/1ps
`default_nettype none
module sac_tad_gen
    import sac_pkg::*;
(
    // Clock, reset, enable.
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // Control.
    input wire logic i_run,
    input wire logic [1:0] i_clk_sel,
    input wire logic i_rc_tick,
    input wire logic i_sleep,
    // Tick out.
    output logic o_half_tick
);
    logic [3:0] cnt_ff, nxt_cnt;
    logic [3:0] lim;
    logic osc_run;

    // ---------------------------------------------------------------
    // Divider
    // ---------------------------------------------------------------
    // [RULE17] sleep stops divided sources
    assign osc_run = i_run && !i_sleep && (i_clk_sel != CLK_RC);

    // [RULE4] divisor per clock select
    always_comb begin
        case (i_clk_sel)
            CLK_DIV2: lim = HALF_DIV2 - 4'h1;
            CLK_DIV8: lim = HALF_DIV8 - 4'h1;
            default: lim = HALF_DIV32_LAST;
        endcase
        nxt_cnt = cnt_ff;
        if (!osc_run) begin
            nxt_cnt = 4'h0;
        end else if (cnt_ff == lim) begin
            nxt_cnt = 4'h0;
        end else begin
            nxt_cnt = cnt_ff + 4'h1;
        end
        if (i_clk_sel == CLK_RC) begin
            o_half_tick = i_run && i_rc_tick;
        end else begin
            o_half_tick = osc_run && (cnt_ff == lim);
        end
    end

    // The sixteen-clock half period needs the top count; other modes wrap early.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_ff <= 4'h0;
        end else if (i_ce) begin
            cnt_ff <= nxt_cnt;
        end
    end

    property p_sleep_quiet;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_sleep && i_clk_sel != CLK_RC) |-> !o_half_tick;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("tick while asleep"); // [RULE17]

    property p_div2_rate;
        @(posedge i_clk) disable iff (!i_rstn)
        (i_ce && o_half_tick && i_clk_sel == CLK_DIV2 && $stable(i_clk_sel)) ##1
        (i_ce && i_run && !i_sleep && i_clk_sel == CLK_DIV2) |-> o_half_tick;
    endproperty
    a_div2_rate: assert property (p_div2_rate) else $error("div2 rate wrong"); // [RULE4]
endmodule
`default_nettype wire
